// >>> hdl/sbsi_top.sv
// Purpose: Backplane bus slave front end with address recognition and stop.
// Assumes: Bus pins are asynchronous to pclk; jumpers are static.
// Notes: Destination bits are numbered 0 (MSB) to 23 as on the bus.
`timescale 1ns/1ps
`include "sbsi_consts.svh"
module sbsi_top import sbsi_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        input_latch_strobe,
  input  wire logic [31:0] bus_data_line,
  input  wire logic [0:23] destination_line,
  input  wire logic        transfer_valid_tag,
  input  wire logic        memory_target_tag,
  input  wire logic        command_register_select,
  input  wire sbsi_kind_s  access_kind,
  input  wire logic [5:0]  address_jumpers,
  input  wire logic        panel_jumper,
  output logic      [0:23] buffered_destination_line,
  output logic      [0:23] destination_out,
  output logic      [15:0] bus_data_out,
  output logic             transfer_accept,
  output logic             processor_halt
);
  localparam int          SW = 63;
  // Idle pin levels: strobe and transfer tag high, so reset release makes no false edge.
  localparam logic [SW-1:0] IDLE = {1'b1, 32'h0000_0000, 24'h00_0000, 1'b1, 1'b0, 1'b0, 3'h0};
  localparam logic [2:0]  HOLD_CYC = 3'(`SBSI_HOLD_CYC);
  localparam logic [2:0]  FLOW_CYC = 3'(`SBSI_FLOW_CYC);

  // Three-stage input capture; a bit changes once stages two and three agree.
  logic [SW-1:0] s1, s2, s3, sq, next_sq;
  logic [SW-1:0] raw;
  assign raw = {input_latch_strobe, bus_data_line, destination_line,
                transfer_valid_tag, memory_target_tag, command_register_select,
                access_kind};
  always_comb begin
    next_sq = (s2 & s3) | (sq & (s2 | s3));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      sq <= IDLE;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      sq <= next_sq;
    end
  end
  logic        strb;
  logic [31:0] din;
  logic [0:23] dest;
  logic        tx_n, mem_t, cmd_sel;
  sbsi_kind_s  kind;
  assign {strb, din, dest, tx_n, mem_t, cmd_sel, kind} = sq;

  // Jumpers are read once, the cycle after reset releases.
  logic       cfg_done;
  logic [5:0] jmp;
  logic       panel_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done <= 1'b0;
      jmp      <= '0;
      panel_en <= 1'b0;
    end else if (!cfg_done) begin
      cfg_done <= 1'b1;
      jmp      <= address_jumpers;
      panel_en <= panel_jumper;
    end
  end

  // Latch strobe sequencer.
  sbsi_latch_e st, next_st;
  logic [2:0]  cnt, next_cnt;
  logic [31:0] lat, next_lat;
  logic        strb_d, fall, cap;
  assign fall = strb_d & ~strb;
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_lat = lat;
    cap      = 1'b0;
    case (st)
      SBSI_OPEN: begin
        next_lat = din;
        if (fall) begin
          cap      = 1'b1;
          next_st  = SBSI_HOLD;
          next_cnt = HOLD_CYC - 3'h1;
        end
      end
      SBSI_HOLD: begin
        if (cnt == 3'h0) next_st = SBSI_OPEN;
        else next_cnt = cnt - 3'h1;
      end
      default: next_st = SBSI_OPEN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st     <= SBSI_OPEN;
      cnt    <= 3'h0;
      lat    <= '0;
      strb_d <= 1'b1;
    end else begin
      st     <= next_st;
      cnt    <= next_cnt;
      lat    <= next_lat;
      strb_d <= strb;
    end
  end

  // Address recognition runs every cycle so it settles before the strobe falls.
  logic acc, next_acc, eq_board;
  assign eq_board = (dest[9:14] == jmp);
  always_comb begin
    next_acc = ~tx_n & mem_t & dest[8] & eq_board;
  end

  // Input file: eight 4-bit slices, each four entries deep.
  logic [1:0] wp, rp, next_wp, next_rp;
  logic [2:0] fcnt, next_fcnt;
  logic       pop, push;
  logic [31:0] fout;
  assign push = cap & (fcnt != 3'h4);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_slice
      logic [3:0] mem [4];
      always_ff @(posedge pclk) begin
        if (push) mem[wp] <= din[g*4 +: 4];
      end
      assign fout[g*4 +: 4] = mem[rp];
    end
  endgenerate
  always_comb begin
    next_wp   = push ? wp + 2'h1 : wp;
    next_rp   = (pop && fcnt != 3'h0) ? rp + 2'h1 : rp;
    next_fcnt = fcnt + {2'h0, push} - {2'h0, pop && fcnt != 3'h0};
  end

  // Register state.
  sbsi_ctrl_s  ctrl, next_ctrl;
  logic [23:0] single_transfer_address_register, mac, stop, cmp;
  logic [23:0] next_mar, next_mac, next_stop, next_cmp;
  logic [15:0] ofile, next_ofile;
  logic [31:0] rb, rnb, rcmd, next_rb, next_rnb, next_rcmd;
  logic [23:0] dreg, next_dreg;
  logic [31:0] rd, next_rd;
  logic        rdy, next_rdy, err, next_err, hlt, next_hlt;
  logic [0:23] dout, next_dout;
  logic        wr, rdacc, setup, okaddr;
  logic [31:0] w;
  assign setup = psel & ~penable;
  assign wr    = psel & penable & rdy & pwrite;
  assign rdacc = psel & penable & rdy & ~pwrite;
  assign w     = pwdata;
  assign pop   = rdacc & (paddr == `SBSI_OFF_INFILE);
  assign okaddr = (paddr[1:0] == 2'b00) && (paddr <= `SBSI_OFF_DEST);

  always_comb begin
    next_ctrl  = ctrl;
    next_mar   = single_transfer_address_register;
    next_mac   = mac;
    next_stop  = stop;
    next_cmp   = cmp;
    next_ofile = ofile;
    next_rb    = rb;
    next_rnb   = rnb;
    next_rcmd  = rcmd;
    next_dreg  = dreg;
    if (wr) begin
      case (paddr)
        `SBSI_OFF_CTRL:    next_ctrl = sbsi_ctrl_s'(w[5:0]);
        `SBSI_OFF_MAR_HI:  next_mar[23:16] = w[7:0];
        `SBSI_OFF_MAR_LO:  next_mar[15:0]  = w[15:0];
        `SBSI_OFF_MAC_HI:  next_mac[23:16] = w[7:0];
        `SBSI_OFF_MAC_LO:  next_mac[15:0]  = w[15:0];
        `SBSI_OFF_STOP_HI: next_stop[23:16] = w[7:0];
        `SBSI_OFF_STOP_LO: begin
          next_stop[15:0] = w[15:0];
          next_cmp = {stop[23:16], w[15:0]};
        end
        `SBSI_OFF_OUT: begin
          if (ctrl.out_capture) next_ofile = w[15:0];
          if (ctrl.burst) begin
            if (ctrl.count_down) next_mac = mac - `SBSI_WORD_STEP;
            else next_mac = mac + `SBSI_WORD_STEP;
          end
        end
        default: ;
      endcase
    end
    // The match is taken from the same filtered pins as the strobe edge, so it
    // must not lag the capture by the register stage of transfer_accept.
    if (cap && next_acc) begin
      if (cmd_sel) begin
        next_rcmd = din;
        next_dreg = dest;
      end else if (dest[15]) next_rb = din;
      else next_rnb = din;
    end
    next_dout = ctrl.burst ? mac : single_transfer_address_register;
    next_hlt  = panel_en & (stop == cmp) & (cmp == 24'(dest))
                & |(ctrl.qual & kind);
    next_rdy  = setup;
    next_err  = setup & ~okaddr;
    next_rd   = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        `SBSI_OFF_CTRL:    next_rd = {26'h0, ctrl};
        `SBSI_OFF_STAT:    next_rd = {26'h0, panel_en, hlt, acc, fcnt};
        `SBSI_OFF_MAR_HI:  next_rd = {24'h0, single_transfer_address_register[23:16]};
        `SBSI_OFF_MAR_LO:  next_rd = {16'h0, single_transfer_address_register[15:0]};
        `SBSI_OFF_MAC_HI:  next_rd = {24'h0, mac[23:16]};
        `SBSI_OFF_MAC_LO:  next_rd = {16'h0, mac[15:0]};
        `SBSI_OFF_STOP_HI: next_rd = {24'h0, stop[23:16]};
        `SBSI_OFF_STOP_LO: next_rd = {16'h0, stop[15:0]};
        `SBSI_OFF_OUT:     next_rd = {16'h0, ofile};
        `SBSI_OFF_INFILE:  next_rd = fout;
        `SBSI_OFF_BURST:   next_rd = rb;
        `SBSI_OFF_NBURST:  next_rd = rnb;
        `SBSI_OFF_CMD:     next_rd = rcmd;
        `SBSI_OFF_DEST:    next_rd = {8'h0, dreg};
        default:           next_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= sbsi_ctrl_s'(`SBSI_CTRL_RST);
      single_transfer_address_register   <= '0;
      mac   <= '0;
      stop  <= '0;
      cmp   <= '0;
      ofile <= '0;
      rb    <= '0;
      rnb   <= '0;
      rcmd  <= '0;
      dreg  <= '0;
      rd    <= '0;
      rdy   <= 1'b0;
      err   <= 1'b0;
      hlt   <= 1'b0;
      dout  <= '0;
      acc   <= 1'b0;
      wp    <= '0;
      rp    <= '0;
      fcnt  <= '0;
      buffered_destination_line <= '0;
    end else begin
      ctrl  <= next_ctrl;
      single_transfer_address_register   <= next_mar;
      mac   <= next_mac;
      stop  <= next_stop;
      cmp   <= next_cmp;
      ofile <= next_ofile;
      rb    <= next_rb;
      rnb   <= next_rnb;
      rcmd  <= next_rcmd;
      dreg  <= next_dreg;
      rd    <= next_rd;
      rdy   <= next_rdy;
      err   <= next_err;
      hlt   <= next_hlt;
      dout  <= next_dout;
      acc   <= next_acc;
      wp    <= next_wp;
      rp    <= next_rp;
      fcnt  <= next_fcnt;
      buffered_destination_line <= dest;
    end
  end

  assign prdata          = rd;
  assign pready          = rdy;
  assign pslverr         = err;
  assign destination_out = dout;
  assign bus_data_out    = ofile;
  assign transfer_accept = acc;
  assign processor_halt  = hlt;

  // Checks.
  a_hold_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st == SBSI_HOLD) |-> (st == SBSI_HOLD) [*6] ##1 st == SBSI_OPEN)
    else $error("latch hold length wrong");
  a_flow_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (st == SBSI_OPEN && !fall) |=> $stable(fcnt) || $past(pop))
    else $error("word entered file without a latch");
  a_file_push: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && fcnt < 3'h4 && !pop) |=> fcnt == $past(fcnt) + 3'h1)
    else $error("latched word not stored");
  a_out_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `SBSI_OFF_OUT && !ctrl.out_capture) |=> $stable(ofile))
    else $error("output file took ignored data");
  a_addr_source: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 destination_out == ($past(ctrl.burst) ? $past(mac) : $past(single_transfer_address_register)))
    else $error("wrong address source");
  a_mac_step: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `SBSI_OFF_OUT && ctrl.burst && !ctrl.count_down)
    |=> mac == $past(mac) + 24'h000004)
    else $error("burst counter did not step");
  a_accept_gate: assert property (@(posedge pclk) disable iff (!presetn)
    transfer_accept |-> $past(!tx_n && mem_t && dest[8] && dest[9:14] == jmp))
    else $error("accept without full match");
  a_halt_gate: assert property (@(posedge pclk) disable iff (!presetn)
    processor_halt |-> $past(panel_en && |(ctrl.qual & kind)))
    else $error("halt without qualifier or panel enable");
  a_cmd_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && next_acc && cmd_sel) |=> dreg == 24'($past(dest)))
    else $error("command destination not latched");
endmodule : sbsi_top

// >>> hdl/sbsi_consts.svh
// Purpose: Constants for the system bus slave interface.
// Assumes: pclk at 40 MHz, APB register access.
// Notes: Offsets are byte addresses on the APB.
// Behaviour
// - While strobe low, hold latched 32-bit bus data 140 ns, then release.
// - Last 35 ns of strobe high, data flows through and is ignored.
// - Each latched word enters an input file of 4-bit slices, 4 deep; the code drops a word latched while the file already holds 4.
// - Output file captures or ignores internal bits 0-15, drives them out.
// - Single address register and burst counter are both 24 bits.
// - Each 24-bit address takes two bus cycles, one per portion.
// - Burst transfers use the counter, all others the single register.
// - Preset burst counter steps one word up or down per transfer.
// - Single register drives destination lines for single transfers.
// - All 24 destination lines pass a permanent non-inverting buffer.
// - Processor command transfers latch destination into an input register.
// - Stop register loads compare register; destination compared for equality.
// - Read, write, fetch qualifiers gate matches, ORed into halt.
// - Bits 9-14 match jumper address; contents captured at cycle end.
// - Bit 8 set means processor; clear means bits 9-15 are board address; the code accepts only with bit 8 high and bits 9-14 equal to the jumpers.
// - Bit 15 excluded from board match, answering an even/odd pair.
// - Bit 15 picks burst or nonburst register; select pin picks command.
// - Accept only with tag low, memory tag high, bit 8 high, equal.
// - Compare mid cycle; result valid by end of cycle.
// - Installed jumper expects one, absent jumper expects zero.
// - Seventh jumper enables panel functions and halt; eighth does nothing.
`ifndef SBSI_CONSTS_SVH
`define SBSI_CONSTS_SVH
`define SBSI_CLK_MHZ      40
`define SBSI_HOLD_NS      140
`define SBSI_FLOW_NS      35
`define SBSI_HOLD_CYC     ((`SBSI_HOLD_NS * `SBSI_CLK_MHZ + 999) / 1000)
`define SBSI_FLOW_CYC     ((`SBSI_FLOW_NS * `SBSI_CLK_MHZ + 999) / 1000)
`define SBSI_WORD_STEP    24'h000004
`define SBSI_OFF_CTRL     8'h00
`define SBSI_OFF_STAT     8'h04
`define SBSI_OFF_MAR_HI   8'h08
`define SBSI_OFF_MAR_LO   8'h0C
`define SBSI_OFF_MAC_HI   8'h10
`define SBSI_OFF_MAC_LO   8'h14
`define SBSI_OFF_STOP_HI  8'h18
`define SBSI_OFF_STOP_LO  8'h1C
`define SBSI_OFF_OUT      8'h20
`define SBSI_OFF_INFILE   8'h24
`define SBSI_OFF_BURST    8'h28
`define SBSI_OFF_NBURST   8'h2C
`define SBSI_OFF_CMD      8'h30
`define SBSI_OFF_DEST     8'h34
`define SBSI_CTRL_RST     6'h00
`endif

// >>> hdl/sbsi_pkg.sv
// Purpose: Types for the system bus slave interface.
// Assumes: Constants come from the header.
// Notes: None.
package sbsi_pkg;
  typedef enum logic [1:0] {
    SBSI_OPEN = 2'b00,
    SBSI_HOLD = 2'b01
  } sbsi_latch_e;
  typedef struct packed {
    logic fetch;
    logic op_write;
    logic op_read;
  } sbsi_kind_s;
  typedef struct packed {
    sbsi_kind_s qual;
    logic       out_capture;
    logic       count_down;
    logic       burst;
  } sbsi_ctrl_s;
endpackage : sbsi_pkg

// >>> test/sbsi_bus_model.sv
// Purpose: Backplane model that sends transfers into the slave interface.
// Assumes: One transfer at a time; strobe low for seven clock cycles.
// Notes: Released data lines show the inverse of the last word, so stale data never matches.
`timescale 1ns/1ps
module sbsi_bus_model (
  input  wire logic        pclk,
  output logic             input_latch_strobe,
  output logic      [31:0] bus_data_line,
  output logic      [0:23] destination_line,
  output logic             transfer_valid_tag,
  output logic             memory_target_tag,
  output logic             command_register_select
);
  initial begin
    input_latch_strobe      = 1'b1;
    bus_data_line           = 32'h5A5A5A5A;
    destination_line        = 24'h000000;
    transfer_valid_tag      = 1'b1;
    memory_target_tag       = 1'b0;
    command_register_select = 1'b0;
  end
  // The destination stays parked between transfers, as the stop compare watches it always.
  task automatic park(input logic [0:23] dest);
    @(posedge pclk);
    destination_line <= dest;
  endtask : park
  task automatic send(input logic [0:23] dest, input logic [31:0] data, input logic mem,
                      input logic cmd);
    @(posedge pclk);
    destination_line        <= dest;
    bus_data_line           <= data;
    memory_target_tag       <= mem;
    command_register_select <= cmd;
    transfer_valid_tag      <= 1'b0;
    input_latch_strobe      <= 1'b0;
    repeat (7) @(posedge pclk);
    input_latch_strobe <= 1'b1;
    repeat (3) @(posedge pclk);
    transfer_valid_tag      <= 1'b1;
    memory_target_tag       <= 1'b0;
    command_register_select <= 1'b0;
    bus_data_line           <= ~data;
    repeat (6) @(posedge pclk);
  endtask : send
endmodule : sbsi_bus_model

// >>> test/test_system_bus_slave_interface.sv
// Purpose: Self-checking bench for the system bus slave interface.
// Assumes: APB answers one cycle after setup; jumpers are static from reset.
// Notes: Backplane transfers come from the bus model.
`timescale 1ns/1ps
`include "sbsi_consts.svh"
module test_system_bus_slave_interface import sbsi_pkg::*;;
  localparam logic [5:0] JMP = 6'h2D;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, panel_jumper;
  logic        input_latch_strobe, transfer_valid_tag, memory_target_tag;
  logic        command_register_select, transfer_accept, processor_halt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, bus_data_line;
  logic [0:23] destination_line, buffered_destination_line, destination_out;
  logic [15:0] bus_data_out;
  logic [5:0]  address_jumpers;
  sbsi_kind_s  access_kind;
  int          error_cnt, total_checks;

  sbsi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_latch_strobe(input_latch_strobe),
    .bus_data_line(bus_data_line), .destination_line(destination_line),
    .transfer_valid_tag(transfer_valid_tag), .memory_target_tag(memory_target_tag),
    .command_register_select(command_register_select), .access_kind(access_kind),
    .address_jumpers(address_jumpers), .panel_jumper(panel_jumper),
    .buffered_destination_line(buffered_destination_line),
    .destination_out(destination_out), .bus_data_out(bus_data_out),
    .transfer_accept(transfer_accept), .processor_halt(processor_halt));
  sbsi_bus_model bus_u (.pclk(pclk), .input_latch_strobe(input_latch_strobe),
    .bus_data_line(bus_data_line), .destination_line(destination_line),
    .transfer_valid_tag(transfer_valid_tag), .memory_target_tag(memory_target_tag),
    .command_register_select(command_register_select));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high at an edge; a bounded wait stops a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 16) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'(pready), 32'h1);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rdc

  function automatic logic [0:23] dst(input logic b8, input logic [5:0] j, input logic b15);
    dst = 24'h000000;
    dst[8] = b8;
    dst[9:14] = j;
    dst[15] = b15;
  endfunction : dst

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdc(`SBSI_OFF_STAT, 32'h00000020);
    chk(32'(transfer_accept), 32'h0);
    apb(1'b0, 8'h3C, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_addr();
    wr(`SBSI_OFF_CTRL, 32'h0);
    wr(`SBSI_OFF_MAR_HI, 32'h12);
    wr(`SBSI_OFF_MAR_LO, 32'h3456);
    chk(32'(destination_out), 32'h00123456);
    rdc(`SBSI_OFF_MAR_HI, 32'h12);
    rdc(`SBSI_OFF_MAR_LO, 32'h3456);
    wr(`SBSI_OFF_MAC_HI, 32'hAB);
    wr(`SBSI_OFF_MAC_LO, 32'hFFFC);
    wr(`SBSI_OFF_CTRL, 32'h05);
    chk(32'(destination_out), 32'h00ABFFFC);
    wr(`SBSI_OFF_OUT, 32'hBEEF);
    chk(32'(bus_data_out), 32'hBEEF);
    rdc(`SBSI_OFF_MAC_HI, 32'hAC);
    rdc(`SBSI_OFF_MAC_LO, 32'h0);
    wr(`SBSI_OFF_CTRL, 32'h03);
    wr(`SBSI_OFF_OUT, 32'h1111);
    chk(32'(bus_data_out), 32'hBEEF);
    chk(32'(destination_out), 32'h00ABFFFC);
    $display("address test done");
  endtask : t_addr

  task automatic t_recv();
    bus_u.send(dst(1'b1, JMP, 1'b0), 32'hC0DE0001, 1'b1, 1'b0);
    rdc(`SBSI_OFF_NBURST, 32'hC0DE0001);
    rdc(`SBSI_OFF_INFILE, 32'hC0DE0001);
    bus_u.send(dst(1'b1, JMP, 1'b1), 32'hC0DE0002, 1'b1, 1'b0);
    rdc(`SBSI_OFF_BURST, 32'hC0DE0002);
    bus_u.send(dst(1'b1, JMP, 1'b0), 32'hC0DE0003, 1'b1, 1'b1);
    rdc(`SBSI_OFF_CMD, 32'hC0DE0003);
    rdc(`SBSI_OFF_DEST, 32'(dst(1'b1, JMP, 1'b0)));
    bus_u.send(dst(1'b1, JMP, 1'b0), 32'hBAD00001, 1'b0, 1'b0);
    bus_u.send(dst(1'b0, JMP, 1'b0), 32'hBAD00002, 1'b1, 1'b0);
    bus_u.send(dst(1'b1, JMP ^ 6'h20, 1'b0), 32'hBAD00003, 1'b1, 1'b0);
    bus_u.send(dst(1'b1, JMP ^ 6'h01, 1'b0), 32'hBAD00004, 1'b1, 1'b0);
    rdc(`SBSI_OFF_NBURST, 32'hC0DE0001);
    $display("receive test done");
  endtask : t_recv

  task automatic t_halt();
    logic [23:0] v;
    v = dst(1'b1, JMP, 1'b1);
    wr(`SBSI_OFF_STOP_HI, 32'(v[23:16]));
    wr(`SBSI_OFF_STOP_LO, 32'(v[15:0]));
    bus_u.park(dst(1'b1, JMP, 1'b1));
    for (int k = 0; k < 3; k++) begin
      wr(`SBSI_OFF_CTRL, 32'h8 << k);
      access_kind <= sbsi_kind_s'(3'(1 << k));
      repeat (8) @(posedge pclk);
      chk(32'(processor_halt), 32'h1);
      access_kind <= sbsi_kind_s'(3'(1 << ((k + 1) % 3)));
      repeat (8) @(posedge pclk);
      chk(32'(processor_halt), 32'h0);
    end
    bus_u.park(dst(1'b1, JMP, 1'b0));
    access_kind <= sbsi_kind_s'(3'h7);
    wr(`SBSI_OFF_CTRL, 32'h38);
    repeat (8) @(posedge pclk);
    chk(32'(processor_halt), 32'h0);
    chk(32'(buffered_destination_line), 32'(dst(1'b1, JMP, 1'b0)));
    $display("halt test done");
  endtask : t_halt

  initial begin
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    address_jumpers = JMP;
    panel_jumper    = 1'b1;
    access_kind     = sbsi_kind_s'(3'h0);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_addr();
    t_recv();
    t_halt();
    tally_and_finish();
  end

  // The tests need about 300 cycles, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_system_bus_slave_interface
